// [fwcc_cfg.svh]
// Purpose: Constants of the wake-up clock control block
// Assumes: Included by the package and by the design module
// Notes:   Oscillator counts are in edges of the oscillator concerned
`ifndef FWCC_CFG_SVH
`define FWCC_CFG_SVH

// Register port and map
`define FWCC_ADDR_W            8
`define FWCC_SMC_ADDR          8'h00
`define FWCC_SMC_RESET         8'h03

// Field positions in system_mode_control
`define FWCC_BIT_HL_SEL        0
`define FWCC_BIT_IDLE_EN       1
`define FWCC_BIT_HS_RDY        2
`define FWCC_BIT_LS_RDY        3
`define FWCC_BIT_QR_EN         4
`define FWCC_DIV_LSB           5
`define FWCC_DIV_MSB           7

// Divider codes at or below this value select the low-speed clock
`define FWCC_DIV_SLOW_MAX      3'h1

// Settling counts, in oscillator edges
`define FWCC_XTAL_CYCLES       11'h400
`define FWCC_HS_RC_CYCLES      11'h010
`define FWCC_LS_RC_CYCLES      11'h002
`define FWCC_SUB_RESUME_CYCLES 2'h2

// Pin positions in the synchroniser bank
`define FWCC_PIN_HS            0
`define FWCC_PIN_LS            1
`define FWCC_PIN_WAKE          2
`define FWCC_PIN_NUM           3

`endif

// [fwcc_pkg.sv]
// Purpose: Types of the wake-up clock control block
// Assumes: fwcc_cfg.svh holds the numeric constants
// Notes:   State codes are one-hot
`include "fwcc_cfg.svh"
package fwcc_pkg;

  // Operating modes of the clock controller
  typedef enum logic [6:0]
  {
    ST_RUN        = 7'h01,
    ST_IDLE_FULL  = 7'h02,
    ST_IDLE_NOSYS = 7'h04,
    ST_STOP_SUB   = 7'h08,
    ST_DEEP_STOP  = 7'h10,
    ST_WAKE       = 7'h20,
    ST_QUICK      = 7'h40
  } fwcc_state_type;

  // High-speed oscillator kind
  typedef enum logic [1:0]
  {
    HS_XTAL = 2'h0,
    HS_ERC  = 2'h1,
    HS_INTERNAL_HIGH_SPEED_RC = 2'h2
  } fwcc_hs_kind_type;

  // Low-speed oscillator kind
  typedef enum logic
  {
    LS_XTAL = 1'h0,
    LS_IRC  = 1'h1
  } fwcc_ls_kind_type;

  // Register port request
  typedef struct packed
  {
    logic [`FWCC_ADDR_W-1:0] addr;
    logic [7:0]              wdata;
    logic                    wr;
    logic                    rd;
  } fwcc_reg_req_type;

  // System clock selection towards the clock tree
  typedef struct packed
  {
    logic       run_on_sub;
    logic       hs_undivided;
    logic [2:0] div_sel;
  } fwcc_clk_sel_type;

endpackage

// [fwcc_core.sv]
// Purpose: System clock mode control with oscillator ready flags and quick resume
// Assumes: Oscillator outputs and the wake pin are asynchronous to clk_sys_i
// Notes:   halt_i and the idle/sub-clock qualifiers come from logic on clk_sys_i
//
// Overview of operation
// - Low-speed ready rises 1024 edges after wake for crystal, 2 for RC.
// - Low-speed ready is 0 in deep stop, 1 once low oscillator is stable.
// - High-speed ready clears at power-on and sets once the oscillator settles.
// - CPU is held after power-on until high-speed ready, or low-speed ready if low speed is selected, so software sees 1.
// - High-speed ready low in stop or idle without clock; 1024 or 16 edges.
// - Halt with idle enable enters idle; system-clock-on picks full or no clock.
// - Halt with idle enable clear enters a stop mode.
// - Quick resume runs the system from the sub clock until main oscillator settles.
// - Quick resume only from stop with sub clock or idle without clock.
// - Quick resume needs its bit in system_mode_control, a crystal main clock and no low-speed selection.
// - Crystal main clock with quick resume resumes after two sub clock edges.
// - Sub clock runs until 1024 crystal edges, then ready sets and clock swaps.
// - RC system clocks wake after 16 or 2 RC edges, ignoring quick resume.
// - High/low select 1 gives undivided high clock, else the divider field.
`timescale 1ns/1ps
`include "fwcc_cfg.svh"
module fwcc_core
(
  // Clock and reset
  input  wire logic                       clk_sys_i,
  input  wire logic                       srst_i,
  // Register port
  input  wire fwcc_pkg::fwcc_reg_req_type reg_req_i,
  output logic [7:0]                      reg_rdata_o,
  // CPU and mode qualifiers
  input  wire logic                       halt_i,
  input  wire logic                       sys_clock_on_in_idle_i,
  input  wire logic                       sub_clock_active_i,
  input  wire fwcc_pkg::fwcc_hs_kind_type hs_kind_i,
  input  wire fwcc_pkg::fwcc_ls_kind_type ls_kind_i,
  // Asynchronous pins
  input  wire logic                       hs_osc_clk_i,
  input  wire logic                       ls_osc_clk_i,
  input  wire logic                       wake_i,
  // Clock controls
  output logic                            cpu_run_o,
  output logic                            sys_clk_run_o,
  output logic                            sub_clk_run_o,
  output logic                            hs_osc_en_o,
  output logic                            ls_osc_en_o,
  output fwcc_pkg::fwcc_clk_sel_type      clk_sel_o,
  output fwcc_pkg::fwcc_state_type        mode_o
);
  import fwcc_pkg::*;

  // Settling target for an oscillator kind
  function automatic logic [10:0] settle_target(input logic is_xtal, input logic [10:0] rc_cnt);
    settle_target = is_xtal ? `FWCC_XTAL_CYCLES : rc_cnt;
  endfunction

  // Reset image of system_mode_control, split into its writable fields
  localparam logic [7:0] SMC_RST     = `FWCC_SMC_RESET;
  localparam logic [2:0] RST_DIV     = SMC_RST[`FWCC_DIV_MSB:`FWCC_DIV_LSB];
  localparam logic       RST_QR_EN   = SMC_RST[`FWCC_BIT_QR_EN];
  localparam logic       RST_IDLE_EN = SMC_RST[`FWCC_BIT_IDLE_EN];
  localparam logic       RST_HL_SEL  = SMC_RST[`FWCC_BIT_HL_SEL];

  fwcc_state_type           state_ff;
  fwcc_state_type           nxt_state;
  logic [2:0]               div_sel_ff;
  logic                     qr_en_ff;
  logic                     idle_en_ff;
  logic                     hl_sel_ff;
  logic [10:0]              hs_cnt_ff;
  logic [10:0]              ls_cnt_ff;
  logic [1:0]               sub_cnt_ff;
  logic                     por_hold_ff;
  logic [7:0]               rdata_ff;
  fwcc_clk_sel_type         clk_sel_ff;
  logic [`FWCC_PIN_NUM-1:0] pin_s1_ff;
  logic [`FWCC_PIN_NUM-1:0] pin_s2_ff;
  logic [`FWCC_PIN_NUM-1:0] pin_s3_ff;
  logic [`FWCC_PIN_NUM-1:0] pin_raw;
  logic [`FWCC_PIN_NUM-1:0] pin_rise;

  // Pin bank feeding the synchronisers
  assign pin_raw[`FWCC_PIN_HS]   = hs_osc_clk_i;
  assign pin_raw[`FWCC_PIN_LS]   = ls_osc_clk_i;
  assign pin_raw[`FWCC_PIN_WAKE] = wake_i;

  // Two-stage synchroniser and rise detector on the third stage
  genvar gi;
  generate
    for (gi = 0; gi < `FWCC_PIN_NUM; gi++)
    begin : g_sync
      always_ff @(posedge clk_sys_i)
      begin
        if (srst_i)
        begin
          pin_s1_ff[gi] <= 1'b0;
          pin_s2_ff[gi] <= 1'b0;
          pin_s3_ff[gi] <= 1'b0;
        end
        else
        begin
          pin_s1_ff[gi] <= pin_raw[gi];
          pin_s2_ff[gi] <= pin_s1_ff[gi];
          pin_s3_ff[gi] <= pin_s2_ff[gi];
        end
      end
      assign pin_rise[gi] = pin_s2_ff[gi] & ~pin_s3_ff[gi];
    end
  endgenerate

  wire hs_edge   = pin_rise[`FWCC_PIN_HS];
  wire ls_edge   = pin_rise[`FWCC_PIN_LS];
  wire wake_lvl  = pin_s2_ff[`FWCC_PIN_WAKE];

  // Register decode
  wire smc_hit   = (reg_req_i.addr == `FWCC_SMC_ADDR);
  wire smc_wr    = reg_req_i.wr & smc_hit;
  wire smc_rd    = reg_req_i.rd & smc_hit;

  // Clock source decode
  wire slow_sel  = ~hl_sel_ff & (div_sel_ff <= `FWCC_DIV_SLOW_MAX);
  wire hs_xtal   = (hs_kind_i == HS_XTAL);
  wire ls_xtal   = (ls_kind_i == LS_XTAL);
  wire [10:0] hs_target = settle_target(hs_xtal, `FWCC_HS_RC_CYCLES);
  wire [10:0] ls_target = settle_target(ls_xtal, `FWCC_LS_RC_CYCLES);

  // Oscillator enables per mode
  wire st_run    = (state_ff == ST_RUN);
  wire st_ifull  = (state_ff == ST_IDLE_FULL);
  wire st_inos   = (state_ff == ST_IDLE_NOSYS);
  wire st_ssub   = (state_ff == ST_STOP_SUB);
  wire st_deep   = (state_ff == ST_DEEP_STOP);
  wire st_wake   = (state_ff == ST_WAKE);
  wire st_quick  = (state_ff == ST_QUICK);
  wire hs_active = (st_run | st_ifull | st_wake | st_quick) & ~slow_sel;
  wire ls_active = ~st_deep;

  // Ready flags taken from the settling counters.
  // The compare is at-or-above: a kind change while running may lower the
  // target below the count already reached, and the counter must not run
  // on and wrap, which would drop a flag of a settled oscillator.
  wire hs_rdy    = hs_active & (hs_cnt_ff >= hs_target);
  wire ls_rdy    = ls_active & (ls_cnt_ff >= ls_target);
  wire sub_done  = (sub_cnt_ff == `FWCC_SUB_RESUME_CYCLES);

  // Quick resume applies to a crystal main clock woken from sub-clock modes
  wire qr_ok     = qr_en_ff & hs_xtal & ~slow_sel & (st_inos | st_ssub);
  wire main_rdy  = slow_sel ? (ls_rdy & sub_done) : hs_rdy;

  // Mode sequencing
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_RUN:
      begin
        if (halt_i & ~por_hold_ff)
        begin
          if (idle_en_ff)
            nxt_state = sys_clock_on_in_idle_i ? ST_IDLE_FULL : ST_IDLE_NOSYS;
          else
            nxt_state = sub_clock_active_i ? ST_STOP_SUB : ST_DEEP_STOP;
        end
      end
      ST_IDLE_FULL:
      begin
        if (wake_lvl)
          nxt_state = ST_RUN;
      end
      ST_IDLE_NOSYS, ST_STOP_SUB:
      begin
        if (wake_lvl)
          nxt_state = qr_ok ? ST_QUICK : ST_WAKE;
      end
      ST_DEEP_STOP:
      begin
        if (wake_lvl)
          nxt_state = ST_WAKE;
      end
      ST_WAKE:
      begin
        if (main_rdy)
          nxt_state = ST_RUN;
      end
      ST_QUICK:
      begin
        if (hs_rdy)
          nxt_state = ST_RUN;
      end
      default:
      begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  // Mode register
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      state_ff <= ST_RUN;
    else
      state_ff <= nxt_state;
  end

  // Software-writable fields; the ready flag bits are dropped.
  // The flags have no storage here at all: they are views of the
  // settling counters; a write selecting the low-speed clock stops the high-speed one and clears its flag.
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      div_sel_ff <= RST_DIV;
      qr_en_ff   <= RST_QR_EN;
      idle_en_ff <= RST_IDLE_EN;
      hl_sel_ff  <= RST_HL_SEL;
    end
    else if (smc_wr)
    begin
      div_sel_ff <= reg_req_i.wdata[`FWCC_DIV_MSB:`FWCC_DIV_LSB];
      qr_en_ff   <= reg_req_i.wdata[`FWCC_BIT_QR_EN];
      idle_en_ff <= reg_req_i.wdata[`FWCC_BIT_IDLE_EN];
      hl_sel_ff  <= reg_req_i.wdata[`FWCC_BIT_HL_SEL];
    end
  end

  // High-speed settling counter, restarted whenever the oscillator stops.
  // Counting holds once the target is reached, so the flag stays set
  // for as long as the oscillator stays enabled.
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i | ~hs_active)
      hs_cnt_ff <= 11'h000;
    else if (hs_edge & (hs_cnt_ff < hs_target))
      hs_cnt_ff <= hs_cnt_ff + 11'h001;
  end

  // Low-speed settling counter, restarted in deep stop.
  // Only deep stop halts the sub clock, so only there does this restart.
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i | ~ls_active)
      ls_cnt_ff <= 11'h000;
    else if (ls_edge & (ls_cnt_ff < ls_target))
      ls_cnt_ff <= ls_cnt_ff + 11'h001;
  end

  // Sub clock edges since the wake-up started
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i | ~(st_wake | st_quick))
      sub_cnt_ff <= 2'h0;
    else if (ls_edge & ~sub_done)
      sub_cnt_ff <= sub_cnt_ff + 2'h1;
  end

  // Hold the CPU after reset until the high-speed flag is set, or the low-speed flag while the low-speed clock is selected.
  // Software therefore never runs before the flag after reset; later it reads it clear in quick resume or on the low-speed clock.
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      por_hold_ff <= 1'b1;
    else if (hs_rdy | (slow_sel & ls_rdy))
      por_hold_ff <= 1'b0;
  end

  // Read data, one cycle after the strobe; unmapped reads return zero
  wire [7:0] smc_view = {div_sel_ff, qr_en_ff, ls_rdy, hs_rdy, idle_en_ff, hl_sel_ff};
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      rdata_ff <= 8'h00;
    else
      rdata_ff <= smc_rd ? smc_view : 8'h00;
  end

  // System clock selection towards the clock tree
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      clk_sel_ff <= '{run_on_sub: 1'b0, hs_undivided: 1'b1, div_sel: 3'h0};
    else
    begin
      clk_sel_ff.run_on_sub   <= (nxt_state == ST_QUICK);
      clk_sel_ff.hs_undivided <= hl_sel_ff;
      clk_sel_ff.div_sel      <= div_sel_ff;
    end
  end

  // Clock run controls decoded from the mode
  assign cpu_run_o     = (st_run & ~por_hold_ff) | (st_quick & sub_done);
  assign sys_clk_run_o = st_run | st_ifull | (st_quick & sub_done);
  assign sub_clk_run_o = ls_active;
  assign hs_osc_en_o   = hs_active;
  assign ls_osc_en_o   = ls_active;
  assign clk_sel_o     = clk_sel_ff;
  assign mode_o        = state_ff;
  assign reg_rdata_o   = rdata_ff;

endmodule

// [fwcc_core_monitor.sv]
// Purpose: Port assertions for the wake-up clock control block
// Assumes: Bound onto fwcc_core, one clock domain
// Notes:   Flags are seen only through register reads
`timescale 1ns/1ps
module fwcc_core_monitor
(
  // Clock and reset
  input wire logic                       clk_sys_i,
  input wire logic                       srst_i,
  // Register port
  input wire fwcc_pkg::fwcc_reg_req_type reg_req_i,
  input wire logic [7:0]                 reg_rdata_o,
  // Mode qualifiers
  input wire logic                       halt_i,
  input wire logic                       sys_clock_on_in_idle_i,
  input wire logic                       sub_clock_active_i,
  input wire fwcc_pkg::fwcc_hs_kind_type hs_kind_i,
  // Clock controls
  input wire logic                       cpu_run_o,
  input wire logic                       sys_clk_run_o,
  input wire logic                       sub_clk_run_o,
  input wire logic                       hs_osc_en_o,
  input wire fwcc_pkg::fwcc_clk_sel_type clk_sel_o,
  input wire fwcc_pkg::fwcc_state_type   mode_o
);
  import fwcc_pkg::*;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  // A halt that the controller accepts
  wire acc = halt_i && mode_o == ST_RUN && cpu_run_o;

  sleep_entry_a: assert property (acc |=> mode_o inside
    {ST_IDLE_FULL, ST_IDLE_NOSYS, ST_STOP_SUB, ST_DEEP_STOP}) else $error("halt not taken");
  idle_clock_a: assert property (acc && sys_clock_on_in_idle_i |=> mode_o != ST_IDLE_NOSYS)
    else $error("idle lost system clock");
  stop_sub_a: assert property (acc && !sub_clock_active_i |=> mode_o != ST_STOP_SUB)
    else $error("stop kept sub clock");
  full_idle_a: assert property (mode_o == ST_IDLE_FULL |-> sys_clk_run_o && !cpu_run_o)
    else $error("full idle clocks wrong");
  no_clock_a: assert property (mode_o inside {ST_IDLE_NOSYS, ST_STOP_SUB, ST_DEEP_STOP}
    |-> !sys_clk_run_o && !cpu_run_o && !hs_osc_en_o) else $error("sleep clocks wrong");
  deep_sub_a: assert property (mode_o == ST_DEEP_STOP |-> !sub_clk_run_o)
    else $error("sub clock on in deep stop");
  deep_wake_a: assert property ($past(mode_o) == ST_DEEP_STOP |-> mode_o != ST_QUICK)
    else $error("quick resume from deep stop");
  quick_src_a: assert property ($changed(mode_o) && mode_o == ST_QUICK |-> hs_kind_i == HS_XTAL
    && $past(mode_o) inside {ST_IDLE_NOSYS, ST_STOP_SUB}) else $error("bad quick entry");
  run_sub_a: assert property (mode_o == ST_RUN |-> !clk_sel_o.run_on_sub)
    else $error("sub clock kept in run");
  hs_flag_a: assert property ($past(reg_req_i.rd && reg_req_i.addr == 8'h00 && !hs_osc_en_o)
    |-> !reg_rdata_o[2]) else $error("high ready set while stopped");

  // Main scenarios
  cov_idle: cover property (mode_o == ST_IDLE_FULL);
  cov_quick: cover property (mode_o == ST_QUICK && cpu_run_o);
  cov_deep: cover property ($past(mode_o) == ST_DEEP_STOP && mode_o == ST_WAKE);
endmodule

bind fwcc_core fwcc_core_monitor i_mon
(
  .clk_sys_i(clk_sys_i), .srst_i(srst_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
  .halt_i(halt_i), .sys_clock_on_in_idle_i(sys_clock_on_in_idle_i),
  .sub_clock_active_i(sub_clock_active_i), .hs_kind_i(hs_kind_i), .cpu_run_o(cpu_run_o),
  .sys_clk_run_o(sys_clk_run_o), .sub_clk_run_o(sub_clk_run_o), .hs_osc_en_o(hs_osc_en_o),
  .clk_sel_o(clk_sel_o), .mode_o(mode_o)
);

// [tb_fwcc_core.sv]
// Purpose: Self-checking bench for the wake-up clock control block
// Assumes: Oscillators are made from the system clock, gated by their enables
// Notes:   High edge every 4 cycles, low edge every 8
`timescale 1ns/1ps
module tb_fwcc_core;
  import fwcc_pkg::*;
  logic             clk_sys_i = 1'b0;
  logic             srst_i = 1'b1;
  fwcc_reg_req_type req = '0;
  logic             halt = 1'b0, sys_on = 1'b0, sub_on = 1'b1, wake = 1'b0;
  logic             hs_ck = 1'b0, ls_ck = 1'b0;
  fwcc_hs_kind_type hs_kind = HS_XTAL;
  fwcc_ls_kind_type ls_kind = LS_IRC;
  int               l1;
  logic [2:0]       dv = 3'h0;
  logic [7:0]       rdata, d;
  logic [7:0]       reg_rdata_o;
  logic             cpu_run_o, sys_clk_run_o, sub_clk_run_o, hs_osc_en_o, ls_osc_en_o;
  fwcc_clk_sel_type clk_sel_o;
  fwcc_state_type   mode_o;
  int               errors = 0, tests_run = 0, hs_n = 0, ls_n = 0, e0, seed = 46262;
  int               smc_m;

  fwcc_core i_dut
  (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .reg_req_i(req), .reg_rdata_o(reg_rdata_o),
    .halt_i(halt), .sys_clock_on_in_idle_i(sys_on), .sub_clock_active_i(sub_on),
    .hs_kind_i(hs_kind), .ls_kind_i(ls_kind), .hs_osc_clk_i(hs_ck), .ls_osc_clk_i(ls_ck),
    .wake_i(wake), .cpu_run_o(cpu_run_o), .sys_clk_run_o(sys_clk_run_o),
    .sub_clk_run_o(sub_clk_run_o), .hs_osc_en_o(hs_osc_en_o), .ls_osc_en_o(ls_osc_en_o),
    .clk_sel_o(clk_sel_o), .mode_o(mode_o)
  );

  // Clock
  always #2.5 clk_sys_i = ~clk_sys_i;

  // Oscillators stand still while disabled; rising edges are counted
  always @(posedge clk_sys_i)
  begin
    dv <= dv + 3'h1;
    hs_ck <= hs_osc_en_o & dv[1];
    ls_ck <= ls_osc_en_o & dv[2];
    hs_n <= hs_n + int'(hs_osc_en_o & dv[1] & !hs_ck);
    ls_n <= ls_n + int'(ls_osc_en_o & dv[2] & !ls_ck);
  end

  // Range compare; an unknown never matches
  task automatic chk(input logic [11:0] got, input logic [11:0] lo, input logic [11:0] hi);
  begin
    tests_run++;
    if ((got < lo) !== 1'b0 || (got > hi) !== 1'b0)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  end
  endtask

  // Register write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
  begin
    req.addr <= a;
    req.wdata <= v;
    req.wr <= 1'b1;
    @(posedge clk_sys_i);
    req.wr <= 1'b0;
    @(posedge clk_sys_i);
  end
  endtask

  // Register read, data taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
  begin
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk_sys_i);
    req.rd <= 1'b0;
    @(negedge clk_sys_i);
    rdata = reg_rdata_o;
    @(posedge clk_sys_i);
  end
  endtask

  // Halt into a mode, wake, and count high edges until run
  task automatic slp(input logic ie, so, sa, qe, input fwcc_hs_kind_type k,
                     input fwcc_state_type ms, mw, input int lo, hi);
    int n;
    int l0;
  begin
    hs_kind <= k;
    sys_on <= so;
    sub_on <= sa;
    wr(8'h00, {3'h0, qe, 2'h0, ie, 1'b1});
    halt <= 1'b1;
    @(posedge clk_sys_i);
    halt <= 1'b0;
    @(negedge clk_sys_i);
    chk(12'(mode_o), 12'(ms), 12'(ms));
    @(posedge clk_sys_i);
    rd(8'h00);
    chk(12'(rdata[2]), 12'(ms == ST_IDLE_FULL), 12'(ms == ST_IDLE_FULL));
    chk(12'(rdata[3]), 12'(ms != ST_DEEP_STOP), 12'(ms != ST_DEEP_STOP));
    chk(12'({ls_osc_en_o, sub_clk_run_o}), 12'(ms != ST_DEEP_STOP ? 3 : 0),
        12'(ms != ST_DEEP_STOP ? 3 : 0));
    e0 = hs_n;
    l0 = ls_n;
    wake <= 1'b1;
    n = 0;
    while (mode_o === ms && n < 8)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    chk(12'(mode_o), 12'(mw), 12'(mw));
    n = 0;
    while (mw == ST_QUICK && !cpu_run_o && n < 40)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    if (mw == ST_QUICK)
      chk(12'(ls_n - l0), 12'h2, 12'h3);
    if (mw == ST_QUICK)
      chk({mode_o, clk_sel_o}, {ST_QUICK, 5'h10}, {ST_QUICK, 5'h1f});
    while (mode_o !== ST_RUN && n < 6000)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    chk(12'(hs_n - e0), 12'(lo), 12'(hi));
    @(posedge clk_sys_i);
    wake <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    $display("Sleep test for mode %h done", ms);
  end
  endtask

  // Verdict and end of run
  task automatic results;
  begin
    $display("Checks made %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask

  // Watchdog
  initial
  begin
    repeat (60000) @(posedge clk_sys_i);
    errors++;
    results();
  end

  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    e0 = hs_n;
    rd(8'h00);
    chk(12'(rdata), 12'h003, 12'h003);
    for (int n = 0; n < 6000 && cpu_run_o !== 1'b1; n++)
      @(negedge clk_sys_i);
    chk(12'(hs_n - e0), 12'd1024, 12'd1026);
    @(posedge clk_sys_i);
    rd(8'h00);
    chk(12'(rdata), 12'h00f, 12'h00f);
    $display("Power-on test done");
    for (int i = 0; i < 4; i++)
    begin
      d = 8'($random(seed)) | 8'h01;
      smc_m = (d & 8'hf3) | 8'h0c;
      wr(8'h00, d);
      rd(8'h00);
      chk(12'(rdata), 12'(smc_m), 12'(smc_m));
    end
    wr(8'h01, 8'h00);
    rd(8'h00);
    chk(12'(rdata), 12'(smc_m), 12'(smc_m));
    rd(8'h01);
    chk(12'(rdata), 12'h000, 12'h000);
    wr(8'h00, 8'h42);
    @(negedge clk_sys_i);
    chk(12'({clk_sel_o.hs_undivided, clk_sel_o.div_sel}), 12'h2, 12'h2);
    @(posedge clk_sys_i);
    $display("Register test done");
    slp(1, 1, 1, 0, HS_XTAL, ST_IDLE_FULL, ST_RUN, 0, 2);
    slp(1, 0, 1, 0, HS_XTAL, ST_IDLE_NOSYS, ST_WAKE, 1024, 1026);
    slp(0, 1, 1, 0, HS_XTAL, ST_STOP_SUB, ST_WAKE, 1024, 1026);
    slp(0, 0, 0, 1, HS_XTAL, ST_DEEP_STOP, ST_WAKE, 1024, 1026);
    slp(0, 1, 1, 1, HS_INTERNAL_HIGH_SPEED_RC, ST_STOP_SUB, ST_WAKE, 16, 18);
    slp(1, 0, 1, 1, HS_XTAL, ST_IDLE_NOSYS, ST_QUICK, 1024, 1026);
    ls_kind <= LS_XTAL;
    l1 = ls_n;
    slp(0, 0, 0, 0, HS_XTAL, ST_DEEP_STOP, ST_WAKE, 1024, 1026);
    for (int n = 0; n < 3000 && rdata[3] !== 1'b1; n++)
      rd(8'h00);
    chk(12'(ls_n - l1), 12'd1024, 12'd1028);
    wr(8'h00, 8'h02);
    rd(8'h00);
    chk(12'({rdata, hs_osc_en_o}), 12'h014, 12'h014);
    chk(12'(clk_sel_o), 12'h000, 12'h000);
    $display("Crystal and slow mode tests done");
    results();
  end
endmodule
